/* File: otfs_load_model.sv */
// Model of the field loads wired to the output contacts
`timescale 1ns/1ns
`default_nettype none
module otfs_load_model
(
  input wire logic [4:0] term_contact_in,
  input wire logic relay_contact_in,
  output logic [5:0] load_on_out
);
  // A load is energised while its contact is closed
  assign load_on_out = {relay_contact_in, term_contact_in};
endmodule
`default_nettype wire

/* File: otfs_pkg.sv */
// Constants for the output terminal function select block
package otfs_pkg;

  // Wishbone register byte offsets
  localparam logic [7:0] OTFS_ADR_SEL_LO = 8'h00;
  localparam logic [7:0] OTFS_ADR_SEL_HI = 8'h04;
  localparam logic [7:0] OTFS_ADR_POL = 8'h08;
  localparam logic [7:0] OTFS_ADR_FCM = 8'h0c;
  localparam logic [7:0] OTFS_ADR_STAT = 8'h10;

  // Field layout
  localparam int OTFS_SEL_W = 8;
  localparam int OTFS_NUM_OUT = 6;
  localparam int OTFS_RELAY_IDX = 5;
  localparam int OTFS_FCM_W = 2;
  localparam int OTFS_SRC_W = 64;

  // Reset values
  localparam logic [7:0] OTFS_RST_TERM_SEL = 8'h00;
  localparam logic [7:0] OTFS_RST_RELAY_SEL = 8'h05;
  localparam logic [5:0] OTFS_RST_POL = 6'h20;

  // Fault code output modes
  localparam logic [1:0] OTFS_FCM_OFF = 2'h0;
  localparam logic [1:0] OTFS_FCM_3BIT = 2'h1;
  localparam logic [1:0] OTFS_FCM_4BIT = 2'h2;

  // Function codes (decimal codes written in hex)
  localparam logic [5:0] OTFS_CODE_RUN = 6'h00;
  localparam logic [5:0] OTFS_CODE_CONST_SPEED = 6'h01;
  localparam logic [5:0] OTFS_CODE_OVERREACH = 6'h02;
  localparam logic [5:0] OTFS_CODE_OVERLOAD1 = 6'h03;
  localparam logic [5:0] OTFS_CODE_PID_DEV = 6'h04;
  localparam logic [5:0] OTFS_CODE_FAULT = 6'h05;
  localparam logic [5:0] OTFS_CODE_ARRIVED = 6'h06;
  localparam logic [5:0] OTFS_CODE_TORQUE = 6'h07;
  localparam logic [5:0] OTFS_CODE_SUPPLY_LOSS = 6'h08;
  localparam logic [5:0] OTFS_CODE_UNDERVOLT = 6'h09;
  localparam logic [5:0] OTFS_CODE_TQ_LIMIT = 6'h0a;
  localparam logic [5:0] OTFS_CODE_RUN_HOURS = 6'h0b;
  localparam logic [5:0] OTFS_CODE_PWR_HOURS = 6'h0c;
  localparam logic [5:0] OTFS_CODE_THERMAL = 6'h0d;
  localparam logic [5:0] OTFS_CODE_RESERVED = 6'h0e;
  localparam logic [5:0] OTFS_CODE_BRAKE_REL = 6'h13;
  localparam logic [5:0] OTFS_CODE_BRAKE_ERR = 6'h14;
  localparam logic [5:0] OTFS_CODE_ZERO_FREQ = 6'h15;
  localparam logic [5:0] OTFS_CODE_SPEED_DEV = 6'h16;
  localparam logic [5:0] OTFS_CODE_POS_DONE = 6'h17;
  localparam logic [5:0] OTFS_CODE_OVERREACH2 = 6'h18;
  localparam logic [5:0] OTFS_CODE_ARRIVED2 = 6'h19;
  localparam logic [5:0] OTFS_CODE_OVERLOAD2 = 6'h1a;
  localparam logic [5:0] OTFS_CODE_ANALOG_LOST = 6'h1b;
  localparam logic [5:0] OTFS_CODE_PID_FB = 6'h1f;
  localparam logic [5:0] OTFS_CODE_COMM_LOST = 6'h20;
  localparam logic [5:0] OTFS_CODE_LOGIC1 = 6'h21;
  localparam logic [5:0] OTFS_CODE_CAP_LIFE = 6'h27;
  localparam logic [5:0] OTFS_CODE_FAN_DROP = 6'h28;
  localparam logic [5:0] OTFS_CODE_START = 6'h29;
  localparam logic [5:0] OTFS_CODE_HEATSINK = 6'h2a;
  localparam logic [5:0] OTFS_CODE_LOW_CUR = 6'h2b;
  localparam logic [5:0] OTFS_CODE_USER1 = 6'h2c;
  localparam logic [5:0] OTFS_CODE_READY = 6'h32;
  localparam logic [5:0] OTFS_CODE_FWD = 6'h33;
  localparam logic [5:0] OTFS_CODE_REV = 6'h34;
  localparam logic [5:0] OTFS_CODE_MAJOR = 6'h35;
  localparam logic [5:0] OTFS_CODE_WINDOW1 = 6'h36;

endpackage

/* File: otfs_top.sv */
// Output terminal function select with Wishbone register access
`timescale 1ns/1ns
`default_nettype none

// Operation
// RQ1 - Each of terminals 11 to 15 and the relay has its own selector
// RQ2 - Each output has its own contact polarity, applied after selection
// RQ3 - Fault mode 01 drives 3 code bits, mode 02 drives 4 bits
// RQ4 - In fault mode the occupied terminals ignore their selectors
// RQ5 - Codes 00,01,02,06,24,25 route run and frequency arrival signals
// RQ6 - Codes 03,26 overload warnings; 04 PID deviation; 31 PID feedback
// RQ7 - Code 05 general fault, 13 thermal warning, 53 major failure
// RQ8 - Code 08 supply loss, code 09 undervoltage
// RQ9 - Codes 11,12 hour limits; 07 excess torque; 10 torque limited
// RQ10 - Codes 19 to 23 brake, zero frequency, speed deviation, position
// RQ11 - Codes 27 to 29 analog input loss; 54 to 56 window compare
// RQ12 - Code 32 routes communication line loss
// RQ13 - Codes 33 to 38 route logic results 1 to 6
// RQ14 - Codes 44 to 49 route user outputs 1 to 6
// RQ15 - Code 40 fan drop, 42 heatsink hot, 39 unsupported
// RQ16 - Codes 41,43,50,51,52 start, low current, ready, forward, reverse
// RQ17 - Polarity 00 closes contact when on, 01 opens it when on
// RQ18 - Run indication stays on during DC braking
// RQ19 - Reserved codes hold the output inactive
// RQ20 - Outputs are registered, changing one cycle after their cause
module otfs_top
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic run_in,
  input wire logic dc_braking_in,
  input wire logic constant_speed_arrived_in,
  input wire logic freq_overreached_in,
  input wire logic freq_arrived_in,
  input wire logic freq_overreached_second_in,
  input wire logic freq_arrived_second_in,
  input wire logic overload_warning_first_in,
  input wire logic overload_warning_second_in,
  input wire logic pid_deviation_flag_in,
  input wire logic pid_feedback_compare_in,
  input wire logic general_fault_in,
  input wire logic thermal_warning_in,
  input wire logic major_failure_in,
  input wire logic supply_loss_in,
  input wire logic undervoltage_flag_in,
  input wire logic excess_torque_in,
  input wire logic torque_limited_in,
  input wire logic run_hours_exceeded_in,
  input wire logic powered_hours_exceeded_in,
  input wire logic brake_release_in,
  input wire logic brake_fault_in,
  input wire logic zero_freq_detect_in,
  input wire logic speed_deviation_max_in,
  input wire logic positioning_done_in,
  input wire logic [2:0] analog_input_lost_in,
  input wire logic comm_line_lost_in,
  input wire logic [5:0] logic_result_in,
  input wire logic [5:0] user_output_in,
  input wire logic fan_speed_drop_in,
  input wire logic start_contact_in,
  input wire logic heatsink_hot_in,
  input wire logic low_current_flag_in,
  input wire logic drive_ready_in,
  input wire logic forward_turning_in,
  input wire logic reverse_turning_in,
  input wire logic [2:0] window_compare_out_in,
  input wire logic [3:0] fault_code_in,
  output logic [4:0] term_contact_out,
  output logic relay_contact_out
);
  import otfs_pkg::*;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0] func_sel_reg [0:OTFS_NUM_OUT-1];
  logic [OTFS_NUM_OUT-1:0] polarity_reg;
  logic [OTFS_FCM_W-1:0] fault_code_output_mode_reg;
  logic wb_req;
  logic wb_wr;
  logic [31:0] rd_next;
  logic [OTFS_SRC_W-1:0] src_vec;
  logic [OTFS_NUM_OUT-1:0] sel_sig;
  logic [OTFS_NUM_OUT-1:0] contact_next;
  logic [OTFS_NUM_OUT-1:0] contact_reg;

  assign wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign wb_wr = wb_req & wb_we_in;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      for (int i = 0; i < OTFS_RELAY_IDX; i++)
        func_sel_reg[i] <= OTFS_RST_TERM_SEL;
      func_sel_reg[OTFS_RELAY_IDX] <= OTFS_RST_RELAY_SEL;
    end
    else if (wb_wr && wb_adr_in == OTFS_ADR_SEL_LO)
    begin
      for (int b = 0; b < 4; b++)
        if (wb_sel_in[b])
          func_sel_reg[b] <= wb_dat_in[b*OTFS_SEL_W +: OTFS_SEL_W]; // see RQ1
    end
    else if (wb_wr && wb_adr_in == OTFS_ADR_SEL_HI)
    begin
      for (int b = 0; b < 2; b++)
        if (wb_sel_in[b])
          func_sel_reg[4+b] <= wb_dat_in[b*OTFS_SEL_W +: OTFS_SEL_W];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      polarity_reg <= OTFS_RST_POL;
    else if (wb_wr && wb_adr_in == OTFS_ADR_POL && wb_sel_in[0])
      polarity_reg <= wb_dat_in[OTFS_NUM_OUT-1:0]; // see RQ2
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      fault_code_output_mode_reg <= OTFS_FCM_OFF;
    else if (wb_wr && wb_adr_in == OTFS_ADR_FCM && wb_sel_in[0])
      fault_code_output_mode_reg <= wb_dat_in[OTFS_FCM_W-1:0];
  end

  // ----------------------------------------------------------------
  // Wishbone read data and acknowledge, one cycle after the request
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_next = '0;
    unique case (wb_adr_in)
      OTFS_ADR_SEL_LO:
        rd_next = {func_sel_reg[3], func_sel_reg[2],
                   func_sel_reg[1], func_sel_reg[0]};
      OTFS_ADR_SEL_HI:
        rd_next = {16'h0000, func_sel_reg[5], func_sel_reg[4]};
      OTFS_ADR_POL:
        rd_next = {26'h0000000, polarity_reg};
      OTFS_ADR_FCM:
        rd_next = {30'h00000000, fault_code_output_mode_reg};
      OTFS_ADR_STAT:
        rd_next = {26'h0000000, contact_reg};
      default:
        rd_next = '0;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= '0;
    end
    else
    begin
      wb_ack_out <= wb_req;
      wb_dat_out <= (wb_req && !wb_we_in) ? rd_next : '0;
    end
  end

  // ----------------------------------------------------------------
  // Source vector indexed by function code
  // ----------------------------------------------------------------
  always_comb
  begin
    src_vec = '0; // see RQ19
    src_vec[OTFS_CODE_RUN] = run_in | dc_braking_in; // see RQ18
    src_vec[OTFS_CODE_CONST_SPEED] = constant_speed_arrived_in; // see RQ5
    src_vec[OTFS_CODE_OVERREACH] = freq_overreached_in;
    src_vec[OTFS_CODE_ARRIVED] = freq_arrived_in;
    src_vec[OTFS_CODE_OVERREACH2] = freq_overreached_second_in;
    src_vec[OTFS_CODE_ARRIVED2] = freq_arrived_second_in;
    src_vec[OTFS_CODE_OVERLOAD1] = overload_warning_first_in; // see RQ6
    src_vec[OTFS_CODE_OVERLOAD2] = overload_warning_second_in;
    src_vec[OTFS_CODE_PID_DEV] = pid_deviation_flag_in;
    src_vec[OTFS_CODE_PID_FB] = pid_feedback_compare_in;
    src_vec[OTFS_CODE_FAULT] = general_fault_in; // see RQ7
    src_vec[OTFS_CODE_THERMAL] = thermal_warning_in;
    src_vec[OTFS_CODE_MAJOR] = major_failure_in;
    src_vec[OTFS_CODE_SUPPLY_LOSS] = supply_loss_in; // see RQ8
    src_vec[OTFS_CODE_UNDERVOLT] = undervoltage_flag_in;
    src_vec[OTFS_CODE_RUN_HOURS] = run_hours_exceeded_in; // see RQ9
    src_vec[OTFS_CODE_PWR_HOURS] = powered_hours_exceeded_in;
    src_vec[OTFS_CODE_TORQUE] = excess_torque_in;
    src_vec[OTFS_CODE_TQ_LIMIT] = torque_limited_in;
    src_vec[OTFS_CODE_BRAKE_REL] = brake_release_in; // see RQ10
    src_vec[OTFS_CODE_BRAKE_ERR] = brake_fault_in;
    src_vec[OTFS_CODE_ZERO_FREQ] = zero_freq_detect_in;
    src_vec[OTFS_CODE_SPEED_DEV] = speed_deviation_max_in;
    src_vec[OTFS_CODE_POS_DONE] = positioning_done_in;
    for (int k = 0; k < 3; k++)
    begin
      src_vec[OTFS_CODE_ANALOG_LOST + k] = analog_input_lost_in[k]; // see RQ11
      src_vec[OTFS_CODE_WINDOW1 + k] = window_compare_out_in[k];
    end
    src_vec[OTFS_CODE_COMM_LOST] = comm_line_lost_in; // see RQ12
    for (int k = 0; k < 6; k++)
    begin
      src_vec[OTFS_CODE_LOGIC1 + k] = logic_result_in[k]; // see RQ13
      src_vec[OTFS_CODE_USER1 + k] = user_output_in[k]; // see RQ14
    end
    src_vec[OTFS_CODE_CAP_LIFE] = 1'b0; // see RQ15
    src_vec[OTFS_CODE_FAN_DROP] = fan_speed_drop_in;
    src_vec[OTFS_CODE_HEATSINK] = heatsink_hot_in;
    src_vec[OTFS_CODE_START] = start_contact_in; // see RQ16
    src_vec[OTFS_CODE_LOW_CUR] = low_current_flag_in;
    src_vec[OTFS_CODE_READY] = drive_ready_in;
    src_vec[OTFS_CODE_FWD] = forward_turning_in;
    src_vec[OTFS_CODE_REV] = reverse_turning_in;
  end

  // ----------------------------------------------------------------
  // Per-output selection, fault code override and polarity
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < OTFS_NUM_OUT; g++)
    begin : gen_out
      // Codes above the vector width are reserved and read inactive
      assign sel_sig[g] = (func_sel_reg[g] < 8'(OTFS_SRC_W)) ?
                          src_vec[func_sel_reg[g][5:0]] : 1'b0; // see RQ19
      if (g < 4)
      begin : gen_fc
        logic in_fault;
        assign in_fault =
          (fault_code_output_mode_reg == OTFS_FCM_4BIT) ||
          (fault_code_output_mode_reg == OTFS_FCM_3BIT && g < 3); // see RQ3
        assign contact_next[g] = (in_fault ? fault_code_in[g] : sel_sig[g])
                                 ^ polarity_reg[g]; // see RQ4
      end
      else
      begin : gen_plain
        assign contact_next[g] = sel_sig[g] ^ polarity_reg[g]; // see RQ17
      end
    end
  endgenerate

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      contact_reg <= '0;
    else
      contact_reg <= contact_next; // see RQ20
  end

  assign term_contact_out = contact_reg[OTFS_RELAY_IDX-1:0];
  assign relay_contact_out = contact_reg[OTFS_RELAY_IDX];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence seq_run_braking;
    func_sel_reg[OTFS_RELAY_IDX] == {2'b00, OTFS_CODE_RUN} && dc_braking_in &&
    !polarity_reg[OTFS_RELAY_IDX];
  endsequence

  sequence seq_relay_closed;
    ##1 relay_contact_out;
  endsequence

  AST_RUN_DC_BRAKE: assert property ( // see RQ18
    @(posedge clk_in) disable iff (srst_in)
    seq_run_braking |-> seq_relay_closed)
    else $error("relay run output dropped during dc braking");

  AST_FAULT_3BIT: assert property ( // see RQ3
    @(posedge clk_in) disable iff (srst_in)
    fault_code_output_mode_reg == OTFS_FCM_3BIT |=>
    term_contact_out[2:0] ==
    ($past(fault_code_in[2:0]) ^ $past(polarity_reg[2:0])))
    else $error("3 bit fault code not on terminals 11 to 13");

  AST_FAULT_4BIT: assert property ( // see RQ4
    @(posedge clk_in) disable iff (srst_in)
    fault_code_output_mode_reg == OTFS_FCM_4BIT |=>
    term_contact_out[3] == ($past(fault_code_in[3]) ^ $past(polarity_reg[3])))
    else $error("4 bit fault code bit 3 not on terminal 14");

  AST_RESERVED_IDLE: assert property ( // see RQ19
    @(posedge clk_in) disable iff (srst_in)
    func_sel_reg[4] == {2'b00, OTFS_CODE_RESERVED} |=>
    term_contact_out[4] == $past(polarity_reg[4]))
    else $error("reserved code did not hold terminal 15 inactive");

  AST_CAP_LIFE_IDLE: assert property ( // see RQ15
    @(posedge clk_in) disable iff (srst_in)
    func_sel_reg[OTFS_RELAY_IDX] == {2'b00, OTFS_CODE_CAP_LIFE} |=>
    relay_contact_out == $past(polarity_reg[OTFS_RELAY_IDX]))
    else $error("unsupported capacitor code drove the relay");

  AST_MAJOR_ROUTE: assert property ( // see RQ7
    @(posedge clk_in) disable iff (srst_in)
    func_sel_reg[4] == {2'b00, OTFS_CODE_MAJOR} && !polarity_reg[4] |=>
    term_contact_out[4] == $past(major_failure_in))
    else $error("major failure not routed to terminal 15");

  AST_LOGIC6_ROUTE: assert property ( // see RQ13
    @(posedge clk_in) disable iff (srst_in)
    func_sel_reg[4] == {2'b00, OTFS_CODE_LOGIC1 + 6'h05} &&
    polarity_reg[4] |=>
    term_contact_out[4] == !$past(logic_result_in[5]))
    else $error("logic result 6 not routed inverted");

  AST_POLARITY_INV: assert property ( // see RQ17
    @(posedge clk_in) disable iff (srst_in)
    fault_code_output_mode_reg == OTFS_FCM_OFF &&
    func_sel_reg[0] == func_sel_reg[1] && polarity_reg[0] != polarity_reg[1]
    |=> term_contact_out[0] != term_contact_out[1])
    else $error("opposite polarities gave equal contacts");

  AST_POL_WRITE: assert property ( // see RQ20
    @(posedge clk_in) disable iff (srst_in)
    wb_wr && wb_adr_in == OTFS_ADR_POL && wb_sel_in[0] &&
    fault_code_output_mode_reg == OTFS_FCM_OFF ##1 $stable(src_vec) &&
    $stable(func_sel_reg[4]) |=>
    term_contact_out[4] == ($past(sel_sig[4]) ^ $past(wb_dat_in[4], 2)))
    else $error("polarity write not seen on terminal 15 two cycles later");

  AST_ACK_PULSE: assert property (@(posedge clk_in) disable iff (srst_in)
    wb_req |=> wb_ack_out ##1 !wb_ack_out)
    else $error("wishbone ack not a single cycle pulse");

  AST_SEL_WRITE: assert property ( // see RQ1
    @(posedge clk_in) disable iff (srst_in)
    wb_wr && wb_adr_in == OTFS_ADR_SEL_LO && wb_sel_in[0] |=>
    func_sel_reg[0] == $past(wb_dat_in[OTFS_SEL_W-1:0]))
    else $error("selector write not stored for terminal 11");

  AST_TERM14_FREE: assert property ( // see RQ3
    @(posedge clk_in) disable iff (srst_in)
    fault_code_output_mode_reg == OTFS_FCM_3BIT |=>
    term_contact_out[3] == ($past(sel_sig[3]) ^ $past(polarity_reg[3])))
    else $error("3 bit fault mode took over terminal 14");

  AST_FAULT_RELAY: assert property ( // see RQ4
    @(posedge clk_in) disable iff (srst_in)
    fault_code_output_mode_reg != OTFS_FCM_OFF |=> relay_contact_out ==
    ($past(sel_sig[OTFS_RELAY_IDX]) ^ $past(polarity_reg[OTFS_RELAY_IDX])))
    else $error("fault code mode changed the relay output");

  AST_UNKNOWN_IDLE: assert property ( // see RQ19
    @(posedge clk_in) disable iff (srst_in)
    fault_code_output_mode_reg == OTFS_FCM_OFF &&
    func_sel_reg[1] >= 8'(OTFS_SRC_W) |=>
    term_contact_out[1] == $past(polarity_reg[1]))
    else $error("out of range code did not hold terminal 12 inactive");

endmodule

`default_nettype wire

/* File: test_otfs_top.sv */
// Self-checking testbench for the output terminal function select block
`timescale 1ns/1ns
`default_nettype none
module test_otfs_top;
  import otfs_pkg::*;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [63:0] src = 64'h0;
  logic dcb = 1'b0;
  logic [3:0] fcode = 4'h0;
  logic [4:0] term;
  logic relay;
  logic [5:0] load;
  logic [31:0] q;
  logic [5:0] e;
  logic [7:0] ra [5];
  logic [31:0] rv [5];
  int error_cnt = 0;
  int n_tests = 0;

  always #4 clk_in = ~clk_in;

  otfs_top i_dut
  (
    .clk_in(clk_in), .srst_in(srst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .run_in(src[0]),
    .dc_braking_in(dcb), .constant_speed_arrived_in(src[1]),
    .freq_overreached_in(src[2]), .overload_warning_first_in(src[3]),
    .pid_deviation_flag_in(src[4]), .general_fault_in(src[5]),
    .freq_arrived_in(src[6]), .excess_torque_in(src[7]),
    .supply_loss_in(src[8]), .undervoltage_flag_in(src[9]),
    .torque_limited_in(src[10]), .run_hours_exceeded_in(src[11]),
    .powered_hours_exceeded_in(src[12]), .thermal_warning_in(src[13]),
    .brake_release_in(src[19]), .brake_fault_in(src[20]),
    .zero_freq_detect_in(src[21]), .speed_deviation_max_in(src[22]),
    .positioning_done_in(src[23]), .freq_overreached_second_in(src[24]),
    .freq_arrived_second_in(src[25]), .overload_warning_second_in(src[26]),
    .analog_input_lost_in(src[29:27]), .pid_feedback_compare_in(src[31]),
    .comm_line_lost_in(src[32]), .logic_result_in(src[38:33]),
    .fan_speed_drop_in(src[40]), .start_contact_in(src[41]),
    .heatsink_hot_in(src[42]), .low_current_flag_in(src[43]),
    .user_output_in(src[49:44]), .drive_ready_in(src[50]),
    .forward_turning_in(src[51]), .reverse_turning_in(src[52]),
    .major_failure_in(src[53]), .window_compare_out_in(src[56:54]),
    .fault_code_in(fcode), .term_contact_out(term), .relay_contact_out(relay)
  );

  otfs_load_model i_load
  (
    .term_contact_in(term),
    .relay_contact_in(relay),
    .load_on_out(load)
  );

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      $display("[FAIL] bus ack expected 1 seen %b", ack);
      error_cnt++;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic chk_reg(input string nm, input logic [31:0] x,
    input logic [31:0] g);
    n_tests++;
    if (g !== x)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
      error_cnt++;
    end
  endtask

  task automatic chk_pin(input string nm, input logic [5:0] x);
    n_tests++;
    if (load !== x)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, x, load);
      error_cnt++;
    end
  endtask

  function automatic logic defined(input int c);
    return !(c inside {[14:18], 30, 39, [57:63]});
  endfunction

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial
  begin
    #400000;
    error_cnt++;
    summarize();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    ra = '{OTFS_ADR_SEL_LO, OTFS_ADR_SEL_HI, OTFS_ADR_POL, OTFS_ADR_FCM,
           8'h14};
    rv = '{32'h0, 32'h00000500, 32'h20, 32'h0, 32'h0};
    repeat (5) @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    chk_pin("relay inverted at reset", 6'h20);
    for (int k = 0; k < 5; k++)
    begin
      wb(1'b0, ra[k], 4'hf, 32'h0);
      chk_reg("reset value", rv[k], q);
    end
    wb(1'b1, 8'h14, 4'hf, 32'hffffffff);
    wb(1'b0, 8'h14, 4'hf, 32'h0);
    chk_reg("unmapped", 32'h0, q);
    wb(1'b1, OTFS_ADR_STAT, 4'hf, 32'h3f);
    wb(1'b0, OTFS_ADR_STAT, 4'hf, 32'h0);
    chk_reg("status read only", 32'h20, q);
    $display("test registers done");
    // Park the other outputs on unused codes, the relay on the unsupported one
    wb(1'b1, OTFS_ADR_SEL_LO, 4'hf, 32'h0e0e0e00);
    wb(1'b1, OTFS_ADR_SEL_HI, 4'h3, 32'h0000270e);
    wb(1'b1, OTFS_ADR_POL, 4'h1, 32'h0);
    for (int c = 0; c < 64; c++)
    begin
      wb(1'b1, OTFS_ADR_SEL_LO, 4'h1, 32'(c));
      @(posedge clk_in);
      src <= defined(c) ? (64'h1 << c) : ~64'h0;
      @(posedge clk_in);
      #1;
      chk_pin("routed source", {5'h0, defined(c)});
      @(posedge clk_in);
      src <= ~(64'h1 << c);
      @(posedge clk_in);
      #1;
      chk_pin("other sources", 6'h00);
    end
    $display("test code table done");
    wb(1'b1, OTFS_ADR_SEL_LO, 4'hf, 32'h2f2e2d2c);
    wb(1'b1, OTFS_ADR_SEL_HI, 4'h3, 32'h00003130);
    foreach (rv[k])
    begin
      e = (k == 0) ? 6'h00 : (k == 1) ? 6'h3f : 6'h15;
      wb(1'b1, OTFS_ADR_POL, 4'h1, {26'h0, e});
      @(posedge clk_in);
      src <= {14'h0, 6'h26, 44'h0};
      @(posedge clk_in);
      #1;
      chk_pin("polarity", 6'h26 ^ e);
      wb(1'b0, OTFS_ADR_STAT, 4'hf, 32'h0);
      chk_reg("status", {26'h0, 6'h26 ^ e}, q);
    end
    @(posedge clk_in);
    src <= {14'h0, 6'h19, 44'h0};
    #1;
    chk_pin("one cycle hold", 6'h26 ^ e);
    @(posedge clk_in);
    #1;
    chk_pin("one cycle update", 6'h19 ^ e);
    $display("test polarity done");
    wb(1'b1, OTFS_ADR_POL, 4'h1, 32'h01);
    src <= 64'h0;
    fcode <= 4'ha;
    for (int m = 0; m < 4; m++)
    begin
      wb(1'b1, OTFS_ADR_FCM, 4'h1, 32'(m));
      @(posedge clk_in);
      #1;
      e = (m == 1) ? 6'h02 : (m == 2) ? 6'h0a : 6'h00;
      chk_pin("fault code mode", e ^ 6'h01);
    end
    $display("test fault code done");
    wb(1'b1, OTFS_ADR_FCM, 4'h1, 32'h0);
    wb(1'b1, OTFS_ADR_POL, 4'h1, 32'h0);
    wb(1'b1, OTFS_ADR_SEL_LO, 4'h2, 32'hffffff00);
    wb(1'b0, OTFS_ADR_SEL_LO, 4'hf, 32'h0);
    chk_reg("byte enable", 32'h2f2eff2c, q);
    wb(1'b1, OTFS_ADR_SEL_LO, 4'h1, 32'h0);
    wb(1'b1, OTFS_ADR_SEL_HI, 4'h2, 32'h0);
    @(posedge clk_in);
    dcb <= 1'b1;
    @(posedge clk_in);
    #1;
    chk_pin("run while braking", 6'h21);
    $display("test braking done");
    wb(1'b1, OTFS_ADR_SEL_LO, 4'h3, 32'h00003535);
    wb(1'b1, OTFS_ADR_SEL_HI, 4'h1, 32'h00000035);
    wb(1'b1, OTFS_ADR_POL, 4'h1, 32'h02);
    @(posedge clk_in);
    src <= 64'h1 << 53;
    @(posedge clk_in);
    #1;
    chk_pin("major failure", 6'h31);
    wb(1'b1, OTFS_ADR_SEL_HI, 4'h1, 32'h00000026);
    wb(1'b1, OTFS_ADR_POL, 4'h1, 32'h10);
    @(posedge clk_in);
    src <= 64'h1 << 38;
    @(posedge clk_in);
    #1;
    chk_pin("logic result 6 inverted", 6'h20);
    $display("test routing done");
    summarize();
  end
endmodule
`default_nettype wire
